// >>> core/ebr_consts.vh
// constants for the embedded block ram and fifo
// Function
// - shapes 8192x1, 4096x2, 2048x4, 1024x9 everywhere
// - 512x18 only in pseudo dual and fifo
// - each ram port picks its own width; fifo sides both use port a width
// - bits packed lsb to msb, word by word
// - contents loadable before user operation
// - rom means preload, user writes held off
// - address and write data registered at array
// - optional output register stage per port
// - normal mode holds output during writes
// - write through shows written data
// - read before write shows old contents
// - fifo write and read sides kept separate
// - full and almost full on write side
// - empty and almost empty on read side
// - full threshold from 1 to 2^N-1
// - almost thresholds 1 to full-1, empty zero
// - fifo reset clears pointers and flags
// - rewind resets read pointer and flushes read buffer, write side kept
// - output clear sync or async selectable
// - per port local output clear
// - chip wide clear hits both ports
`ifndef EBR_CONSTS_VH
`define EBR_CONSTS_VH
`define EBR_MEM_BITS 14'h2400
`define EBR_DW 5'h12
`define EBR_BA_W 14
`define EBR_PTR_W 14
`define EBR_W1 3'h0
`define EBR_W2 3'h1
`define EBR_W4 3'h2
`define EBR_W9 3'h3
`define EBR_W18 3'h4
`define EBR_MODE_SP 2'h0
`define EBR_MODE_TDP 2'h1
`define EBR_MODE_PDP 2'h2
`define EBR_MODE_FIFO 2'h3
`define EBR_WM_NORMAL 2'h0
`define EBR_WM_WT 2'h1
`define EBR_WM_RBW 2'h2
`define EBR_BUF_DEPTH 2'h2
`endif

// >>> core/ebr_mem.v
// bit-addressed two-port storage array with registered read data
`timescale 1ns/100ps
`include "ebr_consts.vh"
module ebr_mem (
	input wire core_clk,
	input wire a_en,
	input wire a_we,
	input wire [13:0] a_base,
	input wire [17:0] a_mask,
	input wire [17:0] a_wdata,
	output reg [17:0] a_rdata,
	input wire b_en,
	input wire b_we,
	input wire [13:0] b_base,
	input wire [17:0] b_mask,
	input wire [17:0] b_wdata,
	output reg [17:0] b_rdata
);
	reg mem [0:`EBR_MEM_BITS-1];
	integer i;
	integer j;
	// configuration default: all-zero pattern
	initial begin
		for (i = 0; i < `EBR_MEM_BITS; i = i + 1) begin
			mem[i] = 1'b0;
		end
	end
	// port a written after port b at each offset; it wins a same-bit collision when its offset is equal to or above port b's
	always @(posedge core_clk) begin
		for (j = 0; j < `EBR_DW; j = j + 1) begin
			if (b_en && b_we && b_mask[j])
				mem[b_base + j] <= b_wdata[j];
			if (a_en && a_we && a_mask[j])
				mem[a_base + j] <= a_wdata[j];
			// old contents are sampled on the write edge
			if (a_en)
				a_rdata[j] <= a_mask[j] & mem[a_base + j];
			if (b_en)
				b_rdata[j] <= b_mask[j] & mem[b_base + j];
		end
	end
endmodule

// >>> core/ebr_buf.v
// two-entry buffer on the fifo read data path
`timescale 1ns/100ps
`include "ebr_consts.vh"
module ebr_buf (
	input wire core_clk,
	input wire nrst,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [17:0] in_data,
	output reg out_valid,
	input wire out_ready,
	output reg [17:0] out_data,
	output reg [1:0] cnt
);
	reg [17:0] s1_q;
	reg [1:0] cnt_d;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt < `EBR_BUF_DEPTH);
	always @* begin
		cnt_d = cnt;
		if (push && !pop)
			cnt_d = cnt + 2'h1;
		else if (pop && !push)
			cnt_d = cnt - 2'h1;
	end
	always @(posedge core_clk) begin
		if (!nrst || flush) begin
			cnt <= 2'h0;
			out_valid <= 1'b0;
			out_data <= 18'h00000;
			s1_q <= 18'h00000;
		end else begin
			cnt <= cnt_d;
			out_valid <= (cnt_d != 2'h0);
			if (pop && cnt == 2'h2)
				out_data <= s1_q;
			else if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop)))
				out_data <= in_data;
			if (push && cnt == 2'h1 && !pop)
				s1_q <= in_data;
		end
	end
endmodule

// >>> core/ebr_top.v
// embedded ram block: ram, rom and fifo modes with width matching
`timescale 1ns/100ps
`include "ebr_consts.vh"
module ebr_top (
	input wire core_clk,
	input wire nrst,
	input wire [1:0] cfg_mode,
	input wire [2:0] cfg_a_width,
	input wire [2:0] cfg_b_width,
	input wire cfg_a_outreg,
	input wire cfg_b_outreg,
	input wire [1:0] cfg_a_wmode,
	input wire [1:0] cfg_b_wmode,
	input wire cfg_clear_async,
	input wire init_active,
	input wire init_we,
	input wire [8:0] init_addr,
	input wire [17:0] init_data,
	input wire a_clk_en,
	input wire a_we,
	input wire [12:0] a_addr,
	input wire [17:0] a_wdata,
	output wire [17:0] a_rdata,
	input wire b_clk_en,
	input wire b_we,
	input wire [12:0] b_addr,
	input wire [17:0] b_wdata,
	output wire [17:0] b_rdata,
	input wire port_a_out_clear,
	input wire port_b_out_clear,
	input wire chip_wide_clear_n,
	input wire wr_clk_en,
	input wire wr_en,
	input wire [17:0] wr_data,
	input wire rd_clk_en,
	input wire rd_en,
	output wire [17:0] rd_data,
	output wire rd_valid,
	input wire rd_out_ready,
	input wire [13:0] full_thresh,
	input wire [13:0] afull_thresh,
	input wire [13:0] aempty_thresh,
	input wire fifo_reset,
	input wire rd_ptr_rewind,
	output reg full_flag,
	output reg almost_full_flag,
	output reg empty_flag,
	output reg almost_empty_flag
);
	// first bit of a word: word index times width
	function [13:0] bit_base;
		input [12:0] addr;
		input [2:0] wc;
		begin
			case (wc)
				`EBR_W1: bit_base = {1'b0, addr};
				`EBR_W2: bit_base = {1'b0, addr[11:0], 1'b0};
				`EBR_W4: bit_base = {1'b0, addr[10:0], 2'h0};
				`EBR_W9: bit_base = {1'b0, addr[9:0], 3'h0} + {4'h0, addr[9:0]};
				default: bit_base = {1'b0, addr[8:0], 4'h0} + {4'h0, addr[8:0], 1'b0};
			endcase
		end
	endfunction

	function [17:0] wmask;
		input [2:0] wc;
		begin
			case (wc)
				`EBR_W1: wmask = 18'h00001;
				`EBR_W2: wmask = 18'h00003;
				`EBR_W4: wmask = 18'h0000f;
				`EBR_W9: wmask = 18'h001ff;
				default: wmask = 18'h3ffff;
			endcase
		end
	endfunction

	function [13:0] depth_m1;
		input [2:0] wc;
		begin
			case (wc)
				`EBR_W1: depth_m1 = 14'h1fff;
				`EBR_W2: depth_m1 = 14'h0fff;
				`EBR_W4: depth_m1 = 14'h07ff;
				`EBR_W9: depth_m1 = 14'h03ff;
				default: depth_m1 = 14'h01ff;
			endcase
		end
	endfunction

	function [13:0] g2b;
		input [13:0] g;
		integer k;
		begin
			g2b[13] = g[13];
			for (k = 12; k >= 0; k = k - 1) begin
				g2b[k] = g2b[k + 1] ^ g[k];
			end
		end
	endfunction

	function [13:0] b2g;
		input [13:0] b;
		begin
			b2g = b ^ (b >> 1);
		end
	endfunction

	// width codes; 18 bits only where both sides are one-way
	wire allow18 = (cfg_mode == `EBR_MODE_PDP) || (cfg_mode == `EBR_MODE_FIFO);
	wire a18_bad = (cfg_a_width > `EBR_W18) || (cfg_a_width == `EBR_W18 && !allow18);
	wire b18_bad = (cfg_b_width > `EBR_W18) || (cfg_b_width == `EBR_W18 && !allow18);
	wire [2:0] a_wc = a18_bad ? `EBR_W9 : cfg_a_width;
	wire [2:0] b_wc = b18_bad ? `EBR_W9 : cfg_b_width;
	wire fifo_m = (cfg_mode == `EBR_MODE_FIFO) && !init_active;

	reg [13:0] wptr_q;
	reg [13:0] rptr_q;
	reg [13:0] wg_q;
	reg [13:0] rg_q;
	reg [13:0] wg_s1_q;
	reg [13:0] wg_s2_q;
	reg [13:0] rg_s1_q;
	reg [13:0] rg_s2_q;
	wire [1:0] buf_cnt;
	wire buf_in_ready;
	wire [35:0] mem_rd;

	// per-port request, already steered by mode
	reg [1:0] rq_ce;
	reg [1:0] rq_en;
	reg [1:0] rq_we;
	reg [27:0] rq_base;
	reg [35:0] rq_mask;
	reg [35:0] rq_wd;
	reg [1:0] en_q;
	reg [1:0] we_q;
	reg [27:0] base_q;
	reg [35:0] mask_q;
	reg [35:0] wd_q;
	reg [1:0] rd1_q;
	reg [1:0] wt1_q;
	reg [1:0] rd2_q;
	reg [1:0] wt2_q;
	reg [35:0] wd2_q;
	reg [35:0] out_q;

	wire frst = !nrst || fifo_reset;
	wire flush = fifo_m && (fifo_reset || rd_ptr_rewind);
	wire [1:0] inflight = {1'b0, rd1_q[1]} + {1'b0, rd2_q[1]};
	wire [2:0] occ = {1'b0, buf_cnt} + {1'b0, inflight};
	wire room = buf_in_ready && (occ < 3'h2);
	wire push = fifo_m && wr_clk_en && wr_en && !full_flag;
	wire pop = fifo_m && rd_clk_en && rd_en && !empty_flag && room && !rd_ptr_rewind;

	always @* begin
		rq_ce = {b_clk_en, a_clk_en};
		rq_en = {b_clk_en && cfg_mode != `EBR_MODE_SP, a_clk_en};
		rq_we = {b_we && cfg_mode == `EBR_MODE_TDP, a_we};
		rq_base = {bit_base(b_addr, b_wc), bit_base(a_addr, a_wc)};
		rq_mask = {wmask(b_wc), wmask(a_wc)};
		rq_wd = {b_wdata & wmask(b_wc), a_wdata & wmask(a_wc)};
		if (cfg_mode == `EBR_MODE_PDP) begin
			rq_en[0] = a_clk_en && a_we;
			rq_we[0] = 1'b1;
		end
		if (fifo_m) begin
			rq_ce = {rd_clk_en, wr_clk_en};
			rq_en = {pop, push};
			rq_we = 2'h1;
			rq_base = {bit_base(rptr_q[12:0], a_wc), bit_base(wptr_q[12:0], a_wc)};
			rq_mask = {wmask(a_wc), wmask(a_wc)};
			rq_wd = {18'h00000, wr_data & wmask(a_wc)};
		end
		// preload phase owns the array; user ports are shut out
		if (init_active) begin
			rq_en = {1'b0, init_we};
			rq_we = 2'h1;
			rq_base[13:0] = {1'b0, init_addr, 4'h0} + {4'h0, init_addr, 1'b0};
			rq_mask[17:0] = 18'h3ffff;
			rq_wd[17:0] = init_data;
		end
	end

	wire [3:0] wm = {cfg_b_wmode, cfg_a_wmode};
	wire [1:0] oreg = {cfg_b_outreg, cfg_a_outreg};
	wire [1:0] pclr = {port_b_out_clear, port_a_out_clear};

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			reg rd3_q;
			reg wt3_q;
			reg [17:0] d3_q;
			wire kill = (p == 1) && flush;
			wire [1:0] pwm = wm[2*p+1:2*p];
			wire [17:0] mrd = mem_rd[18*p+17:18*p];
			wire [17:0] d2 = wt2_q[p] ? wd2_q[18*p+17:18*p] : mrd;
			wire use_rd = oreg[p] ? rd3_q : rd2_q[p];
			wire use_wt = oreg[p] ? wt3_q : wt2_q[p];
			wire [17:0] val = oreg[p] ? d3_q : d2;
			wire clr_req = pclr[p] || !chip_wide_clear_n;
			wire clr_now = clr_req && (cfg_clear_async || rq_ce[p]);

			always @(posedge core_clk) begin
				if (!nrst || kill) begin
					en_q[p] <= 1'b0;
					rd1_q[p] <= 1'b0;
					wt1_q[p] <= 1'b0;
					rd2_q[p] <= 1'b0;
					wt2_q[p] <= 1'b0;
				end else begin
					en_q[p] <= rq_en[p];
					rd1_q[p] <= rq_en[p] && (!rq_we[p] || pwm == `EBR_WM_RBW);
					wt1_q[p] <= rq_en[p] && rq_we[p] && pwm == `EBR_WM_WT && !init_active;
					rd2_q[p] <= rd1_q[p];
					wt2_q[p] <= wt1_q[p];
				end
				we_q[p] <= rq_we[p];
				base_q[14*p+13:14*p] <= rq_base[14*p+13:14*p];
				mask_q[18*p+17:18*p] <= rq_mask[18*p+17:18*p];
				wd_q[18*p+17:18*p] <= rq_wd[18*p+17:18*p];
				wd2_q[18*p+17:18*p] <= wd_q[18*p+17:18*p];
			end

			always @(posedge core_clk) begin
				if (!nrst || clr_now) begin
					rd3_q <= 1'b0;
					wt3_q <= 1'b0;
					d3_q <= 18'h00000;
					out_q[18*p+17:18*p] <= 18'h00000;
				end else begin
					rd3_q <= rd2_q[p];
					wt3_q <= wt2_q[p];
					d3_q <= d2;
					// a plain write leaves the output alone
					if (use_rd || use_wt)
						out_q[18*p+17:18*p] <= val;
				end
			end
		end
	endgenerate

	assign a_rdata = out_q[17:0];
	assign b_rdata = out_q[35:18];

	ebr_mem u_mem (
		.core_clk(core_clk),
		.a_en(en_q[0]),
		.a_we(we_q[0]),
		.a_base(base_q[13:0]),
		.a_mask(mask_q[17:0]),
		.a_wdata(wd_q[17:0]),
		.a_rdata(mem_rd[17:0]),
		.b_en(en_q[1]),
		.b_we(we_q[1]),
		.b_base(base_q[27:14]),
		.b_mask(mask_q[35:18]),
		.b_wdata(wd_q[35:18]),
		.b_rdata(mem_rd[35:18])
	);

	ebr_buf u_buf (
		.core_clk(core_clk),
		.nrst(nrst),
		.flush(flush),
		.in_valid(fifo_m && rd2_q[1]),
		.in_ready(buf_in_ready),
		.in_data(mem_rd[35:18]),
		.out_valid(rd_valid),
		.out_ready(rd_out_ready),
		.out_data(rd_data),
		.cnt(buf_cnt)
	);

	// thresholds held inside their legal ranges
	wire [13:0] dm1 = depth_m1(a_wc);
	wire [13:0] ft_c = (full_thresh > dm1) ? dm1 : full_thresh;
	wire [13:0] ft_d = (ft_c == 14'h0000) ? 14'h0001 : ft_c;
	wire [13:0] ft_m1 = ft_d - 14'h0001;
	wire [13:0] afull_c = (afull_thresh > ft_m1) ? ft_m1 : afull_thresh;
	wire [13:0] aft_d = (afull_c == 14'h0000) ? 14'h0001 : afull_c;
	wire [13:0] aempty_c = (aempty_thresh > ft_m1) ? ft_m1 : aempty_thresh;
	wire [13:0] aet_d = (aempty_c == 14'h0000) ? 14'h0001 : aempty_c;
	reg [13:0] ft_q;
	reg [13:0] aft_q;
	reg [13:0] aet_q;

	// registered so the clamp chain stays off the flag compare path
	always @(posedge core_clk) begin
		if (!nrst) begin
			ft_q <= 14'h0001;
			aft_q <= 14'h0001;
			aet_q <= 14'h0001;
		end else begin
			ft_q <= ft_d;
			aft_q <= aft_d;
			aet_q <= aet_d;
		end
	end

	// write side
	wire [13:0] wptr_n = wptr_q + {13'h0000, push};
	wire [13:0] cnt_w = wptr_n - g2b(rg_s2_q);
	// read side
	wire [13:0] rptr_n = rd_ptr_rewind ? 14'h0000 : rptr_q + {13'h0000, pop};
	wire [13:0] cnt_r = g2b(wg_s2_q) - rptr_n;

	always @(posedge core_clk) begin
		if (frst) begin
			wptr_q <= 14'h0000;
			wg_q <= 14'h0000;
			rg_s1_q <= 14'h0000;
			rg_s2_q <= 14'h0000;
			full_flag <= 1'b0;
			almost_full_flag <= 1'b0;
		end else if (fifo_m) begin
			wptr_q <= wptr_n;
			wg_q <= b2g(wptr_n);
			rg_s1_q <= rg_q;
			rg_s2_q <= rg_s1_q;
			full_flag <= (cnt_w >= ft_q);
			almost_full_flag <= (cnt_w >= aft_q);
		end
	end

	always @(posedge core_clk) begin
		if (frst) begin
			rptr_q <= 14'h0000;
			rg_q <= 14'h0000;
			wg_s1_q <= 14'h0000;
			wg_s2_q <= 14'h0000;
			empty_flag <= 1'b1;
			almost_empty_flag <= 1'b1;
		end else if (fifo_m) begin
			rptr_q <= rptr_n;
			rg_q <= b2g(rptr_n);
			wg_s1_q <= wg_q;
			wg_s2_q <= wg_s1_q;
			empty_flag <= (cnt_r == 14'h0000);
			almost_empty_flag <= (cnt_r <= aet_q);
		end
	end
endmodule

// >>> testbench/ebr_top_assertions.sv
// concurrent checks on the ram block ports
`timescale 1ns/100ps
module ebr_top_chk (
	input wire core_clk,
	input wire nrst,
	input wire [1:0] cfg_mode,
	input wire [2:0] cfg_a_width,
	input wire cfg_a_outreg,
	input wire [1:0] cfg_a_wmode,
	input wire cfg_clear_async,
	input wire init_active,
	input wire a_clk_en,
	input wire a_we,
	input wire [17:0] a_wdata,
	input wire [17:0] a_rdata,
	input wire [17:0] b_rdata,
	input wire port_a_out_clear,
	input wire port_b_out_clear,
	input wire chip_wide_clear_n,
	input wire rd_en,
	input wire [17:0] rd_data,
	input wire rd_valid,
	input wire rd_out_ready,
	input wire fifo_reset,
	input wire rd_ptr_rewind,
	input wire full_flag,
	input wire almost_full_flag,
	input wire empty_flag,
	input wire almost_empty_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	fifo_clear_a: assert property (fifo_reset |=> empty_flag && almost_empty_flag && !full_flag && !rd_valid)
		else $error("fifo reset left flags or data");
	empty_aempty_a: assert property (empty_flag |-> almost_empty_flag)
		else $error("empty without almost empty");
	full_afull_a: assert property (full_flag |-> almost_full_flag)
		else $error("full without almost full");
	full_hold_a: assert property ((!rd_en && !fifo_reset) [*6] ##0 full_flag |=> full_flag)
		else $error("full dropped without reads");
	stall_hold_a: assert property (rd_valid && !rd_out_ready && !fifo_reset && !rd_ptr_rewind
		|=> rd_valid && $stable(rd_data))
		else $error("read word lost in stall");
	a_clear_a: assert property (cfg_clear_async && port_a_out_clear |=> a_rdata == 18'h0)
		else $error("port a clear ignored");
	b_clear_a: assert property (cfg_clear_async && port_b_out_clear |=> b_rdata == 18'h0)
		else $error("port b clear ignored");
	chip_clear_a: assert property (cfg_clear_async && !chip_wide_clear_n
		|=> a_rdata == 18'h0 && b_rdata == 18'h0)
		else $error("chip clear missed a port");
	write_thru_a: assert property (cfg_mode == 2'h0 && cfg_a_wmode == 2'h1 && !cfg_a_outreg
		&& cfg_a_width == 3'h3 && !init_active && a_clk_en && a_we |-> ##3 a_rdata[8:0] == $past(a_wdata[8:0], 3))
		else $error("write through data wrong");
	cover property (full_flag && almost_full_flag);
	cover property (rd_valid && !rd_out_ready);
	cover property (fifo_reset && !empty_flag);
endmodule
bind ebr_top ebr_top_chk u_chk (.core_clk, .nrst, .cfg_mode, .cfg_a_width, .cfg_a_outreg, .cfg_a_wmode,
	.cfg_clear_async, .init_active, .a_clk_en, .a_we, .a_wdata, .a_rdata, .b_rdata, .port_a_out_clear,
	.port_b_out_clear, .chip_wide_clear_n, .rd_en, .rd_data, .rd_valid, .rd_out_ready, .fifo_reset,
	.rd_ptr_rewind, .full_flag, .almost_full_flag, .empty_flag, .almost_empty_flag);

// >>> testbench/ebr_sink.sv
// user logic sink on the fifo read stream
`timescale 1ns/100ps
module ebr_sink (
	input wire core_clk,
	input wire nrst,
	input wire stall,
	input wire rd_valid,
	input wire [17:0] rd_data,
	output reg rd_out_ready
);
	logic [17:0] q[$];
	initial rd_out_ready = 1'b0;
	always @(posedge core_clk) begin
		if (nrst && rd_valid && rd_out_ready)
			q.push_back(rd_data);
		rd_out_ready <= !stall && nrst;
	end
endmodule

// >>> testbench/ebr_top_test.sv
// self-checking bench for ram, rom and fifo modes
`timescale 1ns/100ps
module ebr_top_test;
	logic core_clk = 1'b0, nrst = 1'b0, cfg_a_outreg = 1'b0, cfg_b_outreg = 1'b0, cfg_clear_async = 1'b1;
	logic [1:0] cfg_mode = 2'h0, cfg_a_wmode = 2'h0, cfg_b_wmode = 2'h0;
	logic [2:0] cfg_a_width = 3'h3, cfg_b_width = 3'h2;
	logic init_active = 1'b0, init_we = 1'b0, a_clk_en = 1'b0, a_we = 1'b0, b_clk_en = 1'b0, b_we = 1'b0;
	logic [8:0] init_addr = 9'h0;
	logic [17:0] init_data = 18'h0, a_wdata = 18'h0, b_wdata = 18'h0, wr_data = 18'h0;
	logic [12:0] a_addr = 13'h0, b_addr = 13'h0;
	logic port_a_out_clear = 1'b0, port_b_out_clear = 1'b0, chip_wide_clear_n = 1'b1;
	logic wr_clk_en = 1'b1, wr_en = 1'b0, rd_clk_en = 1'b1, rd_en = 1'b0;
	logic [13:0] full_thresh = 14'h4, afull_thresh = 14'h3, aempty_thresh = 14'h1;
	logic fifo_reset = 1'b0, rd_ptr_rewind = 1'b0, stall = 1'b1;
	wire [17:0] a_rdata, b_rdata, rd_data;
	wire rd_valid, rd_out_ready, full_flag, almost_full_flag, empty_flag, almost_empty_flag;
	int miscompares = 0, checks = 0;
	ebr_top dut (.core_clk, .nrst, .cfg_mode, .cfg_a_width, .cfg_b_width, .cfg_a_outreg, .cfg_b_outreg,
		.cfg_a_wmode, .cfg_b_wmode, .cfg_clear_async, .init_active, .init_we, .init_addr, .init_data,
		.a_clk_en, .a_we, .a_addr, .a_wdata, .a_rdata, .b_clk_en, .b_we, .b_addr, .b_wdata, .b_rdata,
		.port_a_out_clear, .port_b_out_clear, .chip_wide_clear_n, .wr_clk_en, .wr_en, .wr_data,
		.rd_clk_en, .rd_en, .rd_data, .rd_valid, .rd_out_ready, .full_thresh, .afull_thresh,
		.aempty_thresh, .fifo_reset, .rd_ptr_rewind, .full_flag, .almost_full_flag, .empty_flag,
		.almost_empty_flag);
	ebr_sink u_sink (.core_clk, .nrst, .stall, .rd_valid, .rd_data, .rd_out_ready);
	always #4 core_clk = ~core_clk;
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task chk(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task ram(input logic b, input logic we, input logic [12:0] ad, input logic [17:0] wd);
		@(posedge core_clk);
		a_clk_en <= !b;
		b_clk_en <= b;
		a_we <= we;
		a_addr <= ad;
		b_addr <= ad;
		a_wdata <= wd;
		@(posedge core_clk);
		a_clk_en <= 1'b0;
		b_clk_en <= 1'b0;
		a_we <= 1'b0;
		tick(4);
	endtask
	task t_preload;
		@(posedge core_clk);
		init_active <= 1'b1;
		init_we <= 1'b1;
		init_data <= 18'h2a5c3;
		@(posedge core_clk);
		init_active <= 1'b0;
		init_we <= 1'b0;
		ram(0, 0, 13'h0, 18'h0);
		chk(a_rdata[8:0], 18'h1c3);
		ram(0, 0, 13'h1, 18'h0);
		chk(a_rdata[8:0], 18'h152);
		cfg_mode <= 2'h1;
		cfg_b_width <= 3'h0;
		ram(1, 0, 13'h6, 18'h0);
		chk(b_rdata, 18'h1);
		cfg_b_width <= 3'h1;
		ram(1, 0, 13'h3, 18'h0);
		chk(b_rdata, 18'h3);
		cfg_b_width <= 3'h2;
		ram(1, 0, 13'h2, 18'h0);
		chk(b_rdata[3:0], 18'h5);
		cfg_mode <= 2'h0;
		ram(0, 0, 13'h1, 18'h0);
		chk(a_rdata[8:0], 18'h152);
	endtask
	task t_pdp;
		cfg_mode <= 2'h2;
		cfg_a_width <= 3'h4;
		cfg_b_width <= 3'h4;
		ram(0, 1, 13'h1, 18'h3c5a9);
		ram(1, 0, 13'h1, 18'h0);
		chk(b_rdata, 18'h3c5a9);
		cfg_mode <= 2'h0;
		ram(0, 0, 13'h2, 18'h0);
		chk(a_rdata, 18'h001a9);
		cfg_a_width <= 3'h3;
		cfg_b_width <= 3'h2;
	endtask
	task t_wmodes;
		ram(0, 1, 13'h5, 18'h0a5);
		chk(a_rdata[8:0], 18'h152);
		ram(0, 0, 13'h5, 18'h0);
		chk(a_rdata[8:0], 18'h0a5);
		cfg_a_wmode <= 2'h1;
		ram(0, 1, 13'h5, 18'h033);
		chk(a_rdata[8:0], 18'h033);
		cfg_a_wmode <= 2'h2;
		ram(0, 1, 13'h5, 18'h1e1);
		chk(a_rdata[8:0], 18'h033);
		cfg_a_wmode <= 2'h0;
		cfg_a_outreg <= 1'b1;
		ram(0, 0, 13'h5, 18'h0);
		chk(a_rdata[8:0], 18'h1e1);
		cfg_a_outreg <= 1'b0;
	endtask
	task t_clears;
		port_a_out_clear <= 1'b1;
		tick(1);
		port_a_out_clear <= 1'b0;
		tick(2);
		chk(a_rdata, 18'h0);
		chk(b_rdata, 18'h5);
		cfg_clear_async <= 1'b0;
		ram(0, 0, 13'h0, 18'h0);
		port_a_out_clear <= 1'b1;
		port_b_out_clear <= 1'b1;
		tick(1);
		port_a_out_clear <= 1'b0;
		port_b_out_clear <= 1'b0;
		tick(2);
		chk(a_rdata, 18'h1c3);
		cfg_clear_async <= 1'b1;
		chip_wide_clear_n <= 1'b0;
		tick(1);
		chip_wide_clear_n <= 1'b1;
		tick(2);
		chk(a_rdata | b_rdata, 18'h0);
	endtask
	task push(input int n, input int first);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			wr_en <= 1'b1;
			wr_data <= 18'(first + i);
		end
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask
	task wait_words(input int n);
		for (int i = 0; i < 300 && u_sink.q.size() < n; i++)
			@(posedge core_clk);
		tick(20);
		chk(18'(u_sink.q.size()), 18'(n));
	endtask
	task t_fifo;
		cfg_mode <= 2'h3;
		push(5, 1);
		chk({almost_full_flag, full_flag}, 18'h3);
		tick(6);
		chk(empty_flag, 1'b0);
		rd_en <= 1'b1;
		tick(12);
		chk(18'(u_sink.q.size()), 18'h0);
		stall <= 1'b0;
		wait_words(4);
		for (int i = 0; i < 4; i++)
			chk(u_sink.q[i], 18'(i + 1));
		chk({empty_flag, full_flag}, 18'h2);
		rd_en <= 1'b0;
		rd_ptr_rewind <= 1'b1;
		tick(1);
		rd_ptr_rewind <= 1'b0;
		rd_en <= 1'b1;
		wait_words(8);
		chk(u_sink.q[4], 18'h1);
		rd_en <= 1'b0;
		push(2, 9);
		tick(8);
		chk(empty_flag, 1'b0);
		fifo_reset <= 1'b1;
		tick(1);
		fifo_reset <= 1'b0;
		tick(2);
		chk(empty_flag, 1'b1);
		rd_en <= 1'b1;
		wait_words(8);
	endtask
	initial begin
		tick(10);
		nrst <= 1'b1;
		tick(2);
		chk({empty_flag, almost_empty_flag, full_flag, rd_valid}, 18'hc);
		t_preload();
		t_wmodes();
		t_clears();
		t_pdp();
		t_fifo();
		print_verdict();
	end
	initial begin
		#160000;
		miscompares++;
		print_verdict();
	end
endmodule
